// [rtl/mac_rx_lf.sv]
// Purpose: Receive control frame filter and link fault handling
// Assumes: One 64-bit word or column per valid cycle, first frame byte in [63:56], column lane 0 in [7:0]
// Notes:   Receive path delays every word by one stage to see the header
//
// What this block does
// - Filter bit 4 enables pause frame dropping
// - Filter bit 5 enables control frame dropping
// - Both bits reset to one
// - Bit 0 gates all filtering
// - Active pause filter drops pause frames
// - Active control filter drops other control frames
// - No address filter: pause detect still needs multicast or own address
// - Address filter: pass multicast or own pause
// - Filtering never affects pause flow control
// - Only runt filtering means cut-through
// - Any other criterion means store-and-forward
// - Cut-through accepts every identifiable frame
// - Fault signalling off until software enables it
// - Send remote fault or idle during faults
// - Configuration picks action per fault kind
// - Fault sequences set matching status flag
// - Over 127 clean columns clear status
// - Four same sequences within 128 columns
// - 128 quiet columns return link OK
// - Duplex: receive faults feed transmit internally
// - Receive-only: dedicated fault outputs asserted
//
// The address-and-strobe port and the register addresses are this design's own decisions.
module mac_rx_lf
   import mac_rx_lf_pkg::*;
#(
   parameter int BUILD = BUILD_DUPLEX
)(
   input  wire logic        I_MCLK,
   input  wire logic        I_RESETN,
   input  wire logic [7:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [31:0] O_RDATA,
   input  wire logic        I_RX_VALID,
   input  wire logic        I_RX_SOP,
   input  wire logic        I_RX_EOP,
   input  wire logic [63:0] I_RX_DATA,
   output logic             O_RX_VALID,
   output logic             O_RX_SOP,
   output logic             O_RX_EOP,
   output logic      [63:0] O_RX_DATA,
   output logic             O_PAUSE_DET,
   input  wire logic        I_COL_VALID,
   input  wire logic [63:0] I_COL_D,
   input  wire logic [7:0]  I_COL_C,
   input  wire logic [63:0] I_TX_D,
   input  wire logic [7:0]  I_TX_C,
   output logic      [63:0] O_TX_D,
   output logic      [7:0]  O_TX_C,
   input  wire logic        I_TX_NEAR_END_FAULT_IN,
   input  wire logic        I_TX_FAR_END_FAULT_IN,
   output logic             O_LOCAL_FAULT_STATUS,
   output logic             O_REMOTE_FAULT_STATUS,
   output logic             O_RX_NEAR_END_FAULT,
   output logic             O_RX_FAR_END_FAULT
);

   if (BUILD < BUILD_DUPLEX || BUILD > BUILD_RX_ONLY)
   begin : g_bad_build
      $error("mac_rx_lf: unsupported BUILD value");
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic        glob_en;
   logic        runt_en;
   logic        da_en;
   logic        pause_en;
   logic        ctrl_en;
   logic        lf_en;
   logic [1:0]  loc_act;
   logic [1:0]  rem_act;
   logic [47:0] station;
   logic        local_st;
   logic        remote_st;
   link_e       link;
   logic        store_fwd;
   logic [31:0] next_rdata;

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         glob_en  <= FILT_CTRL_RST[FILT_GLOBAL_BIT];
         runt_en  <= FILT_CTRL_RST[FILT_RUNT_BIT];
         da_en    <= FILT_CTRL_RST[FILT_DA_BIT];
         pause_en <= FILT_CTRL_RST[FILT_PAUSE_BIT];
         ctrl_en  <= FILT_CTRL_RST[FILT_CTRL_BIT];
         lf_en    <= 1'b0;
         loc_act  <= LF_CFG_RST[LF_CFG_LOC_LSB +: 2];
         rem_act  <= LF_CFG_RST[LF_CFG_REM_LSB +: 2];
         station  <= 48'h000000000000;
      end
      else if (I_WR)
      begin
         unique case (I_ADDR)
            FILT_CTRL_ADDR:
            begin
               glob_en  <= I_WDATA[FILT_GLOBAL_BIT];
               runt_en  <= I_WDATA[FILT_RUNT_BIT];
               da_en    <= I_WDATA[FILT_DA_BIT];
               pause_en <= I_WDATA[FILT_PAUSE_BIT];
               ctrl_en  <= I_WDATA[FILT_CTRL_BIT];
            end
            LF_EN_ADDR:  lf_en <= I_WDATA[LF_EN_BIT];
            LF_CFG_ADDR:
            begin
               loc_act <= I_WDATA[LF_CFG_LOC_LSB +: 2];
               rem_act <= I_WDATA[LF_CFG_REM_LSB +: 2];
            end
            STA_LO_ADDR: station[31:0]  <= I_WDATA;
            STA_HI_ADDR: station[47:32] <= I_WDATA[15:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      next_rdata = 32'h00000000;
      unique case (I_ADDR)
         FILT_CTRL_ADDR:
         begin
            next_rdata[FILT_GLOBAL_BIT] = glob_en;
            next_rdata[FILT_RUNT_BIT]   = runt_en;
            next_rdata[FILT_DA_BIT]     = da_en;
            next_rdata[FILT_PAUSE_BIT]  = pause_en;
            next_rdata[FILT_CTRL_BIT]   = ctrl_en;
         end
         LF_EN_ADDR:  next_rdata[LF_EN_BIT] = lf_en;
         LF_CFG_ADDR:
         begin
            next_rdata[LF_CFG_LOC_LSB +: 2] = loc_act;
            next_rdata[LF_CFG_REM_LSB +: 2] = rem_act;
         end
         STATUS_ADDR:
         begin
            next_rdata[ST_LOCAL_BIT]     = local_st;
            next_rdata[ST_REMOTE_BIT]    = remote_st;
            next_rdata[ST_LINK_LSB +: 2] = link;
            next_rdata[ST_SAF_BIT]       = store_fwd;
         end
         STA_LO_ADDR: next_rdata = station[31:0];
         STA_HI_ADDR: next_rdata[15:0] = station[47:32];
         default: ;
      endcase
   end

   // Unmapped addresses read zero; data stands only in the cycle after
   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
         O_RDATA <= 32'h00000000;
      else
         O_RDATA <= I_RD ? next_rdata : 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive filter: one-word hold stage so word 1 (type, opcode) is seen
   // before word 0 leaves

   logic        hold_v;
   logic        hold_sop;
   logic        hold_eop;
   logic [63:0] hold_d;
   logic        keep;
   logic        emit;
   logic        is_ctl;
   logic        is_pause;
   logic        da_ok;
   logic        runt_drop;
   logic        drop_hdr;
   logic        next_keep;

   // Anything but runt rejection forces store-and-forward
   assign store_fwd = glob_en && (pause_en || ctrl_en || da_en);
   // A one-word hold flushes on its own when it ends a frame
   assign emit      = hold_v && (I_RX_VALID || hold_eop);
   assign is_ctl    = !hold_eop && I_RX_DATA[31:16] == ETH_TYPE_CTRL;
   assign is_pause  = is_ctl && I_RX_DATA[15:0] == OPCODE_PAUSE;
   assign da_ok     = hold_d[56] || hold_d[63:16] == station;
   // A single-word frame is shorter than any legal frame
   assign runt_drop = glob_en && runt_en && hold_eop;
   assign drop_hdr  = runt_drop || (store_fwd &&
                      ((pause_en && is_pause) ||
                       (ctrl_en && is_ctl && !is_pause) ||
                       (da_en && !da_ok)));
   // Cut-through keeps everything but runts
   assign next_keep = hold_sop ? !drop_hdr : keep;

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         hold_v   <= 1'b0;
         hold_sop <= 1'b0;
         hold_eop <= 1'b0;
         hold_d   <= 64'h0000000000000000;
      end
      else if (I_RX_VALID)
      begin
         hold_v   <= 1'b1;
         hold_sop <= I_RX_SOP;
         hold_eop <= I_RX_EOP;
         hold_d   <= I_RX_DATA;
      end
      else if (emit)
         hold_v <= 1'b0;
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         keep        <= 1'b1;
         O_RX_VALID  <= 1'b0;
         O_RX_SOP    <= 1'b0;
         O_RX_EOP    <= 1'b0;
         O_RX_DATA   <= 64'h0000000000000000;
         O_PAUSE_DET <= 1'b0;
      end
      else
      begin
         if (emit)
            keep <= next_keep;
         O_RX_VALID <= emit && next_keep;
         O_RX_SOP   <= emit && next_keep && hold_sop;
         O_RX_EOP   <= emit && next_keep && hold_eop;
         if (emit)
            O_RX_DATA <= hold_d;
         // Flow control sees pause frames whatever the filter settings
         O_PAUSE_DET <= emit && hold_sop && is_pause && da_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive link fault monitor, one step per column

   link_e       seq_lo;
   link_e       seq_hi;
   link_e       col_seq;
   link_e       last_seq;
   logic [7:0]  quiet;
   logic [2:0]  seq_cnt;
   logic [2:0]  next_cnt;
   logic        quiet_end;

   assign seq_lo    = seq_of(I_COL_D[31:0], I_COL_C[3:0]);
   assign seq_hi    = seq_of(I_COL_D[63:32], I_COL_C[7:4]);
   assign col_seq   = (seq_lo != LINK_OK) ? seq_lo : seq_hi;
   // The 128th column in a row without a fault sequence
   assign quiet_end = I_COL_VALID && col_seq == LINK_OK
                      && quiet == LF_QUIET_LAST;
   assign next_cnt  = (col_seq == last_seq && seq_cnt != 3'h0)
                      ? ((seq_cnt == LF_SEQ_NEEDED) ? seq_cnt : seq_cnt + 3'h1)
                      : 3'h1;

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         quiet    <= 8'h00;
         seq_cnt  <= 3'h0;
         last_seq <= LINK_OK;
         link     <= LINK_OK;
      end
      else if (I_COL_VALID)
      begin
         if (col_seq != LINK_OK)
         begin
            quiet    <= 8'h00;
            last_seq <= col_seq;
            seq_cnt  <= next_cnt;
            if (next_cnt == LF_SEQ_NEEDED)
               link <= col_seq;
         end
         else if (quiet_end)
         begin
            quiet   <= 8'h00;
            seq_cnt <= 3'h0;
            link    <= LINK_OK;
         end
         else
            quiet <= quiet + 8'h01;
      end
   end

   logic next_local;
   logic next_remote;

   // A sequence in the clearing column cannot coincide with quiet_end
   assign next_local  = (I_COL_VALID && col_seq == LINK_LOCAL) ||
                        (local_st && !quiet_end);
   assign next_remote = (I_COL_VALID && col_seq == LINK_REMOTE) ||
                        (remote_st && !quiet_end);

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         local_st              <= 1'b0;
         remote_st             <= 1'b0;
         O_LOCAL_FAULT_STATUS  <= 1'b0;
         O_REMOTE_FAULT_STATUS <= 1'b0;
         O_RX_NEAR_END_FAULT   <= 1'b0;
         O_RX_FAR_END_FAULT    <= 1'b0;
      end
      else
      begin
         local_st              <= next_local;
         remote_st             <= next_remote;
         O_LOCAL_FAULT_STATUS  <= BUILD == BUILD_DUPLEX && next_local;
         O_REMOTE_FAULT_STATUS <= BUILD == BUILD_DUPLEX && next_remote;
         O_RX_NEAR_END_FAULT   <= BUILD == BUILD_RX_ONLY && next_local;
         O_RX_FAR_END_FAULT    <= BUILD == BUILD_RX_ONLY && next_remote;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit fault response

   logic       tx_near;
   logic       tx_far;
   logic [1:0] act;

   // Duplex uses its own receive flags; transmit-only trusts the inputs
   assign tx_near = (BUILD == BUILD_TX_ONLY) ? I_TX_NEAR_END_FAULT_IN : local_st;
   assign tx_far  = (BUILD == BUILD_TX_ONLY) ? I_TX_FAR_END_FAULT_IN : remote_st;
   // Near-end fault takes precedence over far-end fault
   assign act     = !lf_en ? ACT_NORMAL :
                    tx_near ? loc_act :
                    tx_far ? rem_act : ACT_NORMAL;

   always_ff @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_TX_D <= IDLE_COL_D;
         O_TX_C <= IDLE_COL_C;
      end
      else if (act == ACT_RF_SEQ)
      begin
         O_TX_D <= RF_COL_D;
         O_TX_C <= RF_COL_C;
      end
      else if (act == ACT_IDLE)
      begin
         O_TX_D <= IDLE_COL_D;
         O_TX_C <= IDLE_COL_C;
      end
      else
      begin
         O_TX_D <= I_TX_D;
         O_TX_C <= I_TX_C;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);

   a_reset_filt_bits: assert property ($rose(I_RESETN) |-> pause_en && ctrl_en)
      else $error("filter bits not set after reset");
   a_pause_dropped: assert property (emit && hold_sop && store_fwd && pause_en
      && is_pause |=> !O_RX_VALID) else $error("pause frame not dropped");
   a_ctrl_dropped: assert property (emit && hold_sop && store_fwd && ctrl_en
      && is_ctl && !is_pause |=> !O_RX_VALID) else $error("control frame passed");
   a_pause_passed: assert property (emit && hold_sop && is_pause && !runt_drop
      && !(glob_en && (pause_en || da_en)) && !(store_fwd && ctrl_en && !is_pause)
      |=> O_RX_VALID && O_RX_SOP) else $error("pause frame not passed");
   a_cut_through: assert property (emit && !store_fwd && !runt_drop && hold_sop
      |=> O_RX_VALID ##0 O_RX_DATA == $past(hold_d)) else $error("cut-through drop");
   a_fault_off: assert property (!lf_en |=> O_TX_D == $past(I_TX_D)
      && O_TX_C == $past(I_TX_C)) else $error("fault action while disabled");
   a_rf_sent: assert property (lf_en && tx_near && loc_act == ACT_RF_SEQ
      |=> O_TX_C == RF_COL_C && O_TX_D == RF_COL_D) else $error("no remote fault sent");
   a_status_set: assert property (I_COL_VALID && col_seq == LINK_REMOTE
      |=> remote_st [*2] or ##1 quiet_end) else $error("remote status not set");
   a_status_clear: assert property (quiet_end |=> !local_st && !remote_st
      && link == LINK_OK) else $error("status not cleared after quiet span");
   a_four_seq: assert property (I_COL_VALID && col_seq == LINK_LOCAL &&
      last_seq == LINK_LOCAL && seq_cnt == 3'h3 |=> link == LINK_LOCAL)
      else $error("link state not taken after four sequences");
   a_no_early_link: assert property (link == LINK_OK && I_COL_VALID &&
      seq_cnt < 3'h3 |=> link == LINK_OK) else $error("link fault taken early");

   c_pause_drop: cover property (emit && hold_sop && is_pause && drop_hdr);
   c_link_local: cover property (link == LINK_OK ##1 link == LINK_LOCAL);
   c_link_clear: cover property (link == LINK_REMOTE && quiet_end);
   c_idle_sent:  cover property (act == ACT_IDLE);

endmodule // mac_rx_lf

// [rtl/mac_rx_lf_pkg.sv]
// Purpose: Constants and types for the receive filter and link fault block
// Assumes: 32-bit register port, 64-bit column interface
// Notes:   Byte addresses, field positions and reset values live here
package mac_rx_lf_pkg;
   localparam int        REG_AW          = 8;
   localparam int        REG_DW          = 32;
   localparam logic [7:0] FILT_CTRL_ADDR = 8'h00;
   localparam logic [7:0] LF_EN_ADDR     = 8'h04;
   localparam logic [7:0] LF_CFG_ADDR    = 8'h08;
   localparam logic [7:0] STATUS_ADDR    = 8'h0C;
   localparam logic [7:0] STA_LO_ADDR    = 8'h10;
   localparam logic [7:0] STA_HI_ADDR    = 8'h14;
   // Filter control fields
   localparam int        FILT_GLOBAL_BIT = 0;
   localparam int        FILT_RUNT_BIT   = 1;
   localparam int        FILT_DA_BIT     = 2;
   localparam int        FILT_PAUSE_BIT  = 4;
   localparam int        FILT_CTRL_BIT   = 5;
   localparam logic [31:0] FILT_CTRL_RST = 32'h00000031;
   // Link fault enable and action selection
   localparam int        LF_EN_BIT       = 0;
   localparam int        LF_CFG_LOC_LSB  = 0;
   localparam int        LF_CFG_REM_LSB  = 2;
   localparam logic [31:0] LF_CFG_RST    = 32'h00000009;
   localparam logic [1:0] ACT_NORMAL     = 2'h0;
   localparam logic [1:0] ACT_RF_SEQ     = 2'h1;
   localparam logic [1:0] ACT_IDLE       = 2'h2;
   // Status fields
   localparam int        ST_LOCAL_BIT    = 0;
   localparam int        ST_REMOTE_BIT   = 1;
   localparam int        ST_LINK_LSB     = 2;
   localparam int        ST_SAF_BIT      = 4;
   // Frame header values
   localparam logic [15:0] ETH_TYPE_CTRL = 16'h8808;
   localparam logic [15:0] OPCODE_PAUSE  = 16'h0001;
   // Column characters
   localparam logic [7:0] SEQ_CHAR       = 8'h9C;
   localparam logic [7:0] SEQ_LOCAL      = 8'h01;
   localparam logic [7:0] SEQ_REMOTE     = 8'h02;
   localparam logic [63:0] RF_COL_D      = 64'h07070707_0200009C;
   localparam logic [7:0] RF_COL_C       = 8'hF1;
   localparam logic [63:0] IDLE_COL_D    = 64'h07070707_07070707;
   localparam logic [7:0] IDLE_COL_C     = 8'hFF;
   // Column timing
   localparam logic [7:0] LF_QUIET_LAST  = 8'h7F;
   localparam logic [2:0] LF_SEQ_NEEDED  = 3'h4;
   // Build variants
   localparam int        BUILD_DUPLEX    = 0;
   localparam int        BUILD_TX_ONLY   = 1;
   localparam int        BUILD_RX_ONLY   = 2;

   typedef enum logic [1:0] {LINK_OK, LINK_LOCAL, LINK_REMOTE} link_e;

   // Fault value of a sequence ordered set in one four-lane half column
   function automatic link_e seq_of(logic [31:0] d, logic [3:0] c);
      if (c != 4'h1 || d[7:0] != SEQ_CHAR || d[23:8] != 16'h0000)
         return LINK_OK;
      if (d[31:24] == SEQ_LOCAL)
         return LINK_LOCAL;
      if (d[31:24] == SEQ_REMOTE)
         return LINK_REMOTE;
      return LINK_OK;
   endfunction
endpackage

// [bench/link_partner_model.sv]
// Purpose: Receive column source standing in for the PHY and far-end MAC
// Assumes: One column per clock while a kind other than off is chosen
// Notes:   Kind 0 off, 1 data, 2 local fault sequence, 3 remote fault sequence
module link_partner_model
   import mac_rx_lf_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   input  wire logic [1:0]  i_kind,
   output logic             o_col_valid,
   output logic      [63:0] o_col_d,
   output logic      [7:0]  o_col_c
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [31:0] cnt;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt         <= 32'h0;
         o_col_valid <= 1'b0;
         o_col_d     <= 64'h0;
         o_col_c     <= 8'h0;
      end
      else
      begin
         cnt         <= cnt + 32'h1;
         o_col_valid <= (i_kind != 2'h0);
         case (i_kind)
            // Data changes every column so a stuck path cannot hide
            2'h1: {o_col_d, o_col_c} <= {cnt, ~cnt, 8'h00};
            2'h2: {o_col_d, o_col_c} <= {32'h07070707, SEQ_LOCAL, 16'h0000, SEQ_CHAR, 8'hF1};
            2'h3: {o_col_d, o_col_c} <= {32'h07070707, SEQ_REMOTE, 16'h0000, SEQ_CHAR, 8'hF1};
            // Released lines show the inverse, not a frozen column
            default: {o_col_d, o_col_c} <= ~{o_col_d, o_col_c};
         endcase
      end
   end
endmodule // link_partner_model

// [bench/mac_rx_lf_tb_top.sv]
// Purpose: Self-checking bench for the receive filter and link fault block
// Assumes: Duplex build checked beside receive-only and transmit-only copies, registers reached over the plain strobe port
// Notes:   Each scenario is one task that drives and judges on its own
module mac_rx_lf_tb_top
   import mac_rx_lf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk = 1'b0;
   logic        resetn, wr, rd, rx_valid, rx_sop, rx_eop;
   logic [7:0]  addr, tx_c;
   logic [31:0] wdata;
   logic [63:0] rx_data, tx_d;
   logic [1:0]  kind;
   logic [31:0] rdata;
   logic        o_valid, o_sop, o_eop, pdet, col_valid, lfs, rfs, nef, fef;
   logic        nef2, fef2;
   logic [63:0] tx2_d, first_d;
   logic [7:0]  tx2_c;
   int          n_ends;
   logic [63:0] o_data, col_d, o_tx_d;
   logic [7:0]  col_c, o_tx_c;
   int          miscompares, n_compared, n_words, n_pause;
   localparam logic [63:0] TXPAT = 64'hA5A50F0F3C3C5A5A;
   localparam logic [47:0] MCAST = 48'h0180C2000001;
   localparam logic [47:0] UCAST = 48'h001122334455;

   always #12.5 mclk = ~mclk;

   mac_rx_lf u_dut (.I_MCLK(mclk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_VALID(rx_valid), .I_RX_SOP(rx_sop),
      .I_RX_EOP(rx_eop), .I_RX_DATA(rx_data), .O_RX_VALID(o_valid), .O_RX_SOP(o_sop),
      .O_RX_EOP(o_eop), .O_RX_DATA(o_data), .O_PAUSE_DET(pdet), .I_COL_VALID(col_valid),
      .I_COL_D(col_d), .I_COL_C(col_c), .I_TX_D(tx_d), .I_TX_C(tx_c), .O_TX_D(o_tx_d),
      .O_TX_C(o_tx_c), .I_TX_NEAR_END_FAULT_IN(1'b0), .I_TX_FAR_END_FAULT_IN(1'b0),
      .O_LOCAL_FAULT_STATUS(lfs), .O_REMOTE_FAULT_STATUS(rfs),
      .O_RX_NEAR_END_FAULT(nef), .O_RX_FAR_END_FAULT(fef));

   // Receive-only copy exports its faults; a transmit-only copy is fed from them
   mac_rx_lf #(.BUILD(BUILD_RX_ONLY)) u_dut_rx (.I_MCLK(mclk), .I_RESETN(resetn),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(),
      .I_RX_VALID(rx_valid), .I_RX_SOP(rx_sop), .I_RX_EOP(rx_eop), .I_RX_DATA(rx_data),
      .O_RX_VALID(), .O_RX_SOP(), .O_RX_EOP(), .O_RX_DATA(), .O_PAUSE_DET(),
      .I_COL_VALID(col_valid), .I_COL_D(col_d), .I_COL_C(col_c), .I_TX_D(tx_d),
      .I_TX_C(tx_c), .O_TX_D(), .O_TX_C(), .I_TX_NEAR_END_FAULT_IN(1'b0),
      .I_TX_FAR_END_FAULT_IN(1'b0), .O_LOCAL_FAULT_STATUS(), .O_REMOTE_FAULT_STATUS(),
      .O_RX_NEAR_END_FAULT(nef2), .O_RX_FAR_END_FAULT(fef2));

   mac_rx_lf #(.BUILD(BUILD_TX_ONLY)) u_dut_tx (.I_MCLK(mclk), .I_RESETN(resetn),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(),
      .I_RX_VALID(rx_valid), .I_RX_SOP(rx_sop), .I_RX_EOP(rx_eop), .I_RX_DATA(rx_data),
      .O_RX_VALID(), .O_RX_SOP(), .O_RX_EOP(), .O_RX_DATA(), .O_PAUSE_DET(),
      .I_COL_VALID(1'b0), .I_COL_D(col_d), .I_COL_C(col_c), .I_TX_D(tx_d),
      .I_TX_C(tx_c), .O_TX_D(tx2_d), .O_TX_C(tx2_c), .I_TX_NEAR_END_FAULT_IN(nef2),
      .I_TX_FAR_END_FAULT_IN(fef2), .O_LOCAL_FAULT_STATUS(), .O_REMOTE_FAULT_STATUS(),
      .O_RX_NEAR_END_FAULT(), .O_RX_FAR_END_FAULT());

   link_partner_model u_phy (.i_mclk(mclk), .i_resetn(resetn), .i_kind(kind),
      .o_col_valid(col_valid), .o_col_d(col_d), .o_col_c(col_c));

   always @(posedge mclk)
   begin
      if (o_valid === 1'b1) n_words++;
      if (pdet === 1'b1) n_pause++;
      if (o_valid === 1'b1 && (o_sop === 1'b1 || o_eop === 1'b1)) n_ends++;
      if (o_valid === 1'b1 && o_sop === 1'b1) first_d = o_data;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   // Strobe drops one edge before the next request so no signal is set twice
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      addr <= a; rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check({32'h0, rdata}, {32'h0, exp});
      @(posedge mclk);
   endtask

   task automatic send(input logic [47:0] da, input logic [15:0] typ, input logic [15:0] op,
                       input int ew, input int ep);
      int w0, p0, e0;
      w0 = n_words;
      p0 = n_pause;
      e0 = n_ends;
      first_d = 64'h0;
      rx_valid <= 1'b1; rx_sop <= 1'b1; rx_data <= {da, 16'h0000};
      @(posedge mclk);
      rx_sop <= 1'b0; rx_eop <= 1'b1; rx_data <= {32'h0, typ, op};
      @(posedge mclk);
      rx_valid <= 1'b0; rx_eop <= 1'b0; rx_data <= ~rx_data;
      repeat (4) @(posedge mclk);
      check(64'(n_words - w0), 64'(ew));
      check(64'(n_pause - p0), 64'(ep));
      check(64'(n_ends - e0), 64'(ew));
      if (ew != 0) check(first_d, {da, 16'h0000});
   endtask

   task automatic seq(input logic [1:0] k, input int n, input int gap);
      repeat (n)
      begin
         kind <= k;
         @(posedge mclk);
         kind <= 2'h1;
         repeat (gap) @(posedge mclk);
      end
   endtask

   task automatic txchk(input logic [7:0] c, input logic [63:0] d);
      repeat (2) @(posedge mclk);
      #1 check(o_tx_d, d);
      check({56'h0, o_tx_c}, {56'h0, c});
      check(tx2_d, d);
      check({56'h0, tx2_c}, {56'h0, c});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rchk(FILT_CTRL_ADDR, 32'h00000031);
      rchk(LF_EN_ADDR, 32'h00000000);
      rchk(LF_CFG_ADDR, 32'h00000009);
      rchk(8'h40, 32'h00000000);
      rchk(STATUS_ADDR, 32'h00000010);
      $display("test regs done");
   endtask

   task automatic t_filter;
      logic [31:0] fc [5] = '{32'h31, 32'h11, 32'h21, 32'h30, 32'h01};
      int          pp [5] = '{0, 0, 2, 2, 2};
      int          cp [5] = '{0, 2, 0, 2, 2};
      for (int i = 0; i < 5; i++)
      begin
         wreg(FILT_CTRL_ADDR, fc[i]);
         send(MCAST, ETH_TYPE_CTRL, OPCODE_PAUSE, pp[i], 1);
         send(MCAST, ETH_TYPE_CTRL, 16'h0002, cp[i], 0);
      end
      $display("test filter done");
   endtask

   task automatic t_addr;
      wreg(FILT_CTRL_ADDR, 32'h00000005);
      send(MCAST, ETH_TYPE_CTRL, OPCODE_PAUSE, 2, 1);
      send(UCAST, ETH_TYPE_CTRL, OPCODE_PAUSE, 0, 0);
      wreg(STA_LO_ADDR, 32'h22334455);
      wreg(STA_HI_ADDR, 32'h00000011);
      send(UCAST, ETH_TYPE_CTRL, OPCODE_PAUSE, 2, 1);
      rchk(STATUS_ADDR, 32'h00000010);
      wreg(FILT_CTRL_ADDR, 32'h00000003);
      rchk(STATUS_ADDR, 32'h00000000);
      send(48'h00AABBCCDDEE, 16'h0800, 16'h0000, 2, 0);
      send(MCAST, ETH_TYPE_CTRL, 16'h0002, 2, 0);
      $display("test address and mode done");
   endtask

   task automatic t_fault;
      wreg(FILT_CTRL_ADDR, 32'h00000000);
      seq(2'h2, 1, 20);
      rchk(STATUS_ADDR, 32'h00000001);
      check({62'h0, lfs, nef}, 64'h2);
      check({62'h0, nef2, fef2}, 64'h2);
      seq(2'h2, 2, 20);
      rchk(STATUS_ADDR, 32'h00000001);
      seq(2'h2, 1, 20);
      rchk(STATUS_ADDR, 32'h00000005);
      txchk(8'h00, TXPAT);
      wreg(LF_EN_ADDR, 32'h00000001);
      txchk(RF_COL_C, RF_COL_D);
      wreg(LF_CFG_ADDR, 32'h00000008);
      txchk(8'h00, TXPAT);
      wreg(LF_CFG_ADDR, 32'h00000009);
      seq(2'h2, 1, 100);
      rchk(STATUS_ADDR, 32'h00000005);
      repeat (30) @(posedge mclk);
      rchk(STATUS_ADDR, 32'h00000000);
      seq(2'h3, 4, 20);
      rchk(STATUS_ADDR, 32'h0000000A);
      check({62'h0, rfs, fef}, 64'h2);
      check({62'h0, nef2, fef2}, 64'h1);
      txchk(IDLE_COL_C, IDLE_COL_D);
      wreg(LF_CFG_ADDR, 32'h00000005);
      txchk(RF_COL_C, RF_COL_D);
      wreg(LF_CFG_ADDR, 32'h00000001);
      txchk(8'h00, TXPAT);
      kind <= 2'h0;
      $display("test fault done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      rx_valid = 1'b0; rx_sop = 1'b0; rx_eop = 1'b0; rx_data = 64'h0;
      tx_d = TXPAT; tx_c = 8'h00; kind = 2'h0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      t_regs();
      t_filter();
      t_addr();
      t_fault();
      results();
   end

   // Hang guard: the whole run is far shorter than this
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      results();
   end
endmodule // mac_rx_lf_tb_top
